// ### tcc_pkg.sv
package tcc_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_FLAGS    = 8'h0c;
  localparam logic [7:0] ADDR_T2COUNT  = 8'h11;
  localparam logic [7:0] ADDR_T2CTRL   = 8'h12;
  localparam logic [7:0] ADDR_CCVALLO  = 8'h15;
  localparam logic [7:0] ADDR_CCVALHI  = 8'h16;
  localparam logic [7:0] ADDR_CCCTRL   = 8'h17;
  localparam logic [7:0] ADDR_ENABLES  = 8'h8c;
  localparam logic [7:0] ADDR_T2LIMIT  = 8'h92;
  // Reset values
  localparam logic [7:0] RST_ZERO      = 8'h00;
  localparam logic [7:0] RST_LIMIT     = 8'hff;
  localparam logic [15:0] RST_WORD     = 16'h0000;
  // Field positions
  localparam int FLAG_T1OVF   = 0;
  localparam int FLAG_T2MATCH = 1;
  localparam int FLAG_CC      = 2;
  localparam int T2_RUN       = 2;
  localparam int T2_POST_LO   = 3;
  localparam int CC_DUTY_LO   = 4;
  // Writable masks
  localparam logic [7:0] MASK_FLAGS    = 8'hf7;
  localparam logic [7:0] MASK_T2CTRL   = 8'h7f;
  localparam logic [7:0] MASK_CCCTRL   = 8'h3f;
  // Prescale terminal counts and counter increments
  localparam logic [3:0] PRE_DIV1      = 4'h0;
  localparam logic [3:0] PRE_DIV4      = 4'h3;
  localparam logic [3:0] PRE_DIV16     = 4'hf;
  localparam logic [3:0] EDGE_DIV4     = 4'h3;
  localparam logic [3:0] EDGE_DIV16    = 4'hf;
  localparam logic [3:0] ONE4          = 4'h1;
  localparam logic [7:0] ONE8          = 8'h01;
  // Mode codes
  localparam logic [3:0] M_OFF    = 4'h0;
  localparam logic [3:0] M_CAPF   = 4'h4;
  localparam logic [3:0] M_CAPR   = 4'h5;
  localparam logic [3:0] M_CAP4   = 4'h6;
  localparam logic [3:0] M_CAP16  = 4'h7;
  localparam logic [3:0] M_CMPSET = 4'h8;
  localparam logic [3:0] M_CMPCLR = 4'h9;
  localparam logic [3:0] M_CMPSW  = 4'ha;
  localparam logic [3:0] M_CMPTRG = 4'hb;
endpackage : tcc_pkg

// ### tcc_timer2_ccp.sv
`timescale 1ns/10ps
module tcc_timer2_ccp
  import tcc_pkg::*;
(
  input  wire logic        clk,          // Instruction clock
  input  wire logic        rst,          // Synchronous reset, active high
  input  wire logic [7:0]  regAddr,      // Register address
  input  wire logic [7:0]  regWdata,     // Write data
  input  wire logic        regWr,        // Write strobe
  input  wire logic        regRd,        // Read strobe
  output logic      [7:0]  regRdata,     // Read data, cycle after strobe
  input  wire logic [15:0] timerOneCount,// Timer1 count
  input  wire logic        timerOneWrite,// Software writes Timer1 this cycle
  input  wire logic        timerOneOvf,  // Timer1 overflow event
  input  wire logic        capcmpPinIn,  // Pin level (async)
  output logic             capcmpPinOut, // Compare output latch
  output logic             specialEvent, // Trigger: clear Timer1, start A/D
  output logic             timerMatch,   // Pre-postscaler match pulse
  output logic      [7:0]  timerCount    // Period timer count
);

  logic [7:0]  count;
  logic [7:0]  limit;
  logic [6:0]  t2ctrl;
  logic [5:0]  ccctrl;
  logic [15:0] ccValue;
  logic [7:0]  flags;
  logic [7:0]  enables;
  logic [3:0]  preCnt;
  logic [3:0]  postCnt;
  logic [3:0]  edgeCnt;
  logic [2:0]  pinSync;
  logic        pinStable;
  logic        pinPrev;

  logic        wrCount;
  logic        wrT2Ctrl;
  logic        wrCcCtrl;
  logic        wrFlags;
  logic [3:0]  preTerm;
  logic        tick;
  logic        atLimit;
  logic        postOut;
  logic [3:0]  mode;
  logic        capMode;
  logic        cmpMode;
  logic        riseEv;
  logic        fallEv;
  logic        capture;
  logic        cmpHit;
  logic [7:0]  next_count;
  logic [3:0]  next_preCnt;
  logic [3:0]  next_postCnt;
  logic [3:0]  next_edgeCnt;
  logic [7:0]  next_flags;
  logic [7:0]  next_rdata;
  logic        next_pinOut;
  logic [15:0] next_ccValue;

  function automatic logic hit(input logic [7:0] a);
    hit = regWr && (regAddr == a);
  endfunction : hit

  // Next period count after one tick, wrapping at the limit
  function automatic logic [7:0] stepCount(input logic [7:0] c, input logic [7:0] lim);
    if (c == lim) begin
      stepCount = RST_ZERO;
    end else begin
      stepCount = c + ONE8;
    end
  endfunction : stepCount

  assign wrCount  = hit(ADDR_T2COUNT);
  assign wrT2Ctrl = hit(ADDR_T2CTRL);
  assign wrCcCtrl = hit(ADDR_CCCTRL);
  assign wrFlags  = hit(ADDR_FLAGS);
  assign mode     = ccctrl[3:0];
  assign capMode  = (mode[3:2] == 2'b01);
  assign cmpMode  = (mode[3:2] == 2'b10);

  always_comb begin
    unique case (t2ctrl[1:0])
      2'b00:   preTerm = PRE_DIV1;
      2'b01:   preTerm = PRE_DIV4;
      default: preTerm = PRE_DIV16;
    endcase
  end

  assign tick    = t2ctrl[T2_RUN] && (preCnt == preTerm);
  assign atLimit = (count == limit);
  assign postOut = tick && atLimit && (postCnt == t2ctrl[6:T2_POST_LO]);

  // Prescaler: clears on count and control writes and reset
  always_comb begin
    if (rst || wrCount || wrT2Ctrl) begin
      next_preCnt = PRE_DIV1;
    end else if (!t2ctrl[T2_RUN]) begin
      next_preCnt = preCnt;
    end else if (preCnt == preTerm) begin
      next_preCnt = PRE_DIV1;
    end else begin
      next_preCnt = preCnt + ONE4;
    end
  end

  always_ff @(posedge clk) begin
    preCnt <= next_preCnt;
  end

  // Postscaler counts matches; a stopped timer never advances it
  always_comb begin
    if (rst || wrCount || wrT2Ctrl) begin
      next_postCnt = PRE_DIV1;
    end else if (postOut) begin
      next_postCnt = PRE_DIV1;
    end else if (tick && atLimit) begin
      next_postCnt = postCnt + ONE4;
    end else begin
      next_postCnt = postCnt;
    end
  end

  always_ff @(posedge clk) begin
    postCnt <= next_postCnt;
  end

  // Count write wins over a tick; control writes leave count alone
  always_comb begin
    if (wrCount) begin
      next_count = regWdata;
    end else if (tick) begin
      next_count = stepCount(count, limit);
    end else begin
      next_count = count;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count <= RST_ZERO;
    end else begin
      count <= next_count;
    end
  end

  // New limit takes effect at the next comparison
  always_ff @(posedge clk) begin
    if (rst) begin
      limit <= RST_LIMIT;
    end else if (hit(ADDR_T2LIMIT)) begin
      limit <= regWdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      t2ctrl <= RST_ZERO[6:0];
    end else if (wrT2Ctrl) begin
      t2ctrl <= regWdata[6:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      timerMatch <= 1'b0;
    end else begin
      timerMatch <= tick && atLimit;
    end
  end

  // Mirror of the count, registered so the port comes straight from a flop
  always_ff @(posedge clk) begin
    if (rst) begin
      timerCount <= RST_ZERO;
    end else begin
      timerCount <= next_count;
    end
  end

  // Pin synchronizer; stage 0 only feeds stage 1
  always_ff @(posedge clk) begin
    if (rst) begin
      pinSync <= 3'b000;
    end else begin
      pinSync <= {pinSync[1:0], capcmpPinIn};
    end
  end

  // A change counts only once stages 1 and 2 agree
  always_ff @(posedge clk) begin
    if (rst) begin
      pinStable <= 1'b0;
    end else if (pinSync[1] == pinSync[2]) begin
      pinStable <= pinSync[2];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pinPrev <= 1'b0;
    end else begin
      pinPrev <= pinStable;
    end
  end

  assign riseEv = pinStable && !pinPrev;
  assign fallEv = !pinStable && pinPrev;

  always_comb begin
    capture = 1'b0;
    if (capMode) begin
      unique case (mode)
        M_CAPF:  capture = fallEv;
        M_CAPR:  capture = riseEv;
        M_CAP4:  capture = riseEv && (edgeCnt[1:0] == EDGE_DIV4[1:0]);
        default: capture = riseEv && (edgeCnt == EDGE_DIV16);
      endcase
    end
  end

  // Edge prescaler survives a switch between capture codes
  always_comb begin
    if (rst || !capMode) begin
      next_edgeCnt = PRE_DIV1;
    end else if (riseEv) begin
      next_edgeCnt = edgeCnt + ONE4;
    end else begin
      next_edgeCnt = edgeCnt;
    end
  end

  always_ff @(posedge clk) begin
    edgeCnt <= next_edgeCnt;
  end

  // Flag keeps being set for as long as equality lasts
  assign cmpHit = cmpMode && (timerOneCount == ccValue);

  // A capture beats a software write to the value bytes
  always_comb begin
    next_ccValue = ccValue;
    if (capture) begin
      next_ccValue = timerOneCount;
    end else if (hit(ADDR_CCVALLO)) begin
      next_ccValue[7:0] = regWdata;
    end else if (hit(ADDR_CCVALHI)) begin
      next_ccValue[15:8] = regWdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ccValue <= RST_WORD;
    end else begin
      ccValue <= next_ccValue;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ccctrl <= RST_ZERO[5:0];
    end else if (wrCcCtrl) begin
      ccctrl <= regWdata[5:0];
    end
  end

  // Off write forces the output latch low; the port data latch lives elsewhere
  always_comb begin
    next_pinOut = capcmpPinOut;
    if (wrCcCtrl && regWdata[3:0] == M_OFF) begin
      next_pinOut = 1'b0;
    end else if (cmpHit && mode == M_CMPSET) begin
      next_pinOut = 1'b1;
    end else if (cmpHit && mode == M_CMPCLR) begin
      next_pinOut = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      capcmpPinOut <= 1'b0;
    end else begin
      capcmpPinOut <= next_pinOut;
    end
  end

  // Software Timer1 write suppresses the trigger
  always_ff @(posedge clk) begin
    if (rst) begin
      specialEvent <= 1'b0;
    end else begin
      specialEvent <= cmpHit && (mode == M_CMPTRG) && !timerOneWrite;
    end
  end

  // Hardware set wins over software clear
  always_comb begin
    next_flags = wrFlags ? (regWdata & MASK_FLAGS) : flags;
    if (timerOneOvf) begin
      next_flags[FLAG_T1OVF] = 1'b1;
    end
    if (postOut) begin
      next_flags[FLAG_T2MATCH] = 1'b1;
    end
    if (capture || cmpHit) begin
      next_flags[FLAG_CC] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      flags <= RST_ZERO;
    end else begin
      flags <= next_flags;
    end
  end

  // Enables only store; this block raises no interrupt itself
  always_ff @(posedge clk) begin
    if (rst) begin
      enables <= RST_ZERO;
    end else if (hit(ADDR_ENABLES)) begin
      enables <= regWdata & MASK_FLAGS;
    end
  end

  // Unmapped addresses read as zero
  always_comb begin
    unique case (regAddr)
      ADDR_FLAGS:   next_rdata = flags;
      ADDR_T2COUNT: next_rdata = count;
      ADDR_T2CTRL:  next_rdata = {1'b0, t2ctrl};
      ADDR_CCVALLO: next_rdata = ccValue[7:0];
      ADDR_CCVALHI: next_rdata = ccValue[15:8];
      ADDR_CCCTRL:  next_rdata = {2'b00, ccctrl};
      ADDR_ENABLES: next_rdata = enables;
      ADDR_T2LIMIT: next_rdata = limit;
      default:      next_rdata = RST_ZERO;
    endcase
  end

  // Data stand only in the cycle after the strobe, zero otherwise
  always_ff @(posedge clk) begin
    if (rst || !regRd) begin
      regRdata <= RST_ZERO;
    end else begin
      regRdata <= next_rdata;
    end
  end

endmodule : tcc_timer2_ccp

// ### tcc_t1_model.sv
`timescale 1ns/10ps
module tcc_t1_model (
  input  wire logic        clk,          // Clock
  input  wire logic        rst,          // Reset
  input  wire logic        run,          // Count enable
  input  wire logic        wrEn,         // Software write
  input  wire logic [15:0] wrVal,        // Written value
  input  wire logic        specialEvent, // Clear request
  output logic      [15:0] count,        // Count
  output logic             ovf           // Wrap pulse
);
  // Synchronous timer mode only, so compare and capture stay reliable
  always_ff @(posedge clk) begin
    if (rst) begin
      count <= 16'h0000;
    end else if (wrEn) begin
      count <= wrVal;
    end else if (specialEvent) begin
      count <= 16'h0000;
    end else if (run) begin
      count <= count + 16'h0001;
    end
  end
  always_ff @(posedge clk) begin
    ovf <= !rst && run && !wrEn && !specialEvent && (count == 16'hffff);
  end
endmodule : tcc_t1_model

// ### tcc_timer2_ccp_chk.sv
`timescale 1ns/10ps
module tcc_chk
  import tcc_pkg::*;
(
  input wire logic       clk,           // Clock
  input wire logic       rst,           // Reset
  input wire logic [7:0] regAddr,       // Address
  input wire logic [7:0] regWdata,      // Write data
  input wire logic       regWr,         // Write strobe
  input wire logic       regRd,         // Read strobe
  input wire logic [7:0] regRdata,      // Read data
  input wire logic       timerOneWrite, // Timer1 write
  input wire logic       capcmpPinOut,  // Output latch
  input wire logic       specialEvent,  // Trigger
  input wire logic       timerMatch,    // Match pulse
  input wire logic [7:0] timerCount     // Count
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_offWrite;
    regWr && regAddr == ADDR_CCCTRL && regWdata == 8'h00;
  endsequence
  sequence s_pinLow;
    ##[1:2] !capcmpPinOut;
  endsequence
  property p_ccOff;
    s_offWrite |-> s_pinLow;
  endproperty
  a_ccOff: assert property (p_ccOff) else $error("latch not cleared");
  property p_rdIdle;
    !$past(regRd) |-> regRdata == 8'h00;
  endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data not idle");
  property p_matchZero;
    timerMatch |-> timerCount == 8'h00;
  endproperty
  a_matchZero: assert property (p_matchZero) else $error("match off wrap");
  property p_step;
    $changed(timerCount) && !$past(regWr) && !$past(regWr, 2)
      |-> timerCount == 8'h00 || timerCount == $past(timerCount) + 8'h01;
  endproperty
  a_step: assert property (p_step) else $error("count jump");
  property p_evPulse;
    specialEvent |=> !specialEvent;
  endproperty
  a_evPulse: assert property (p_evPulse) else $error("trigger too long");
  property p_evWrite;
    specialEvent |-> !$past(timerOneWrite);
  endproperty
  a_evWrite: assert property (p_evWrite) else $error("trigger beat write");
  property p_evPin;
    specialEvent |-> $stable(capcmpPinOut);
  endproperty
  a_evPin: assert property (p_evPin) else $error("trigger moved pin");
  property p_rstOut;
    $fell(rst) |-> timerCount == 8'h00 && !capcmpPinOut && !specialEvent && !timerMatch;
  endproperty
  a_rstOut: assert property (p_rstOut) else $error("outputs after reset");
endmodule : tcc_chk

bind tcc_timer2_ccp tcc_chk chk (.clk(clk), .rst(rst), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .timerOneWrite(timerOneWrite), .capcmpPinOut(capcmpPinOut),
  .specialEvent(specialEvent), .timerMatch(timerMatch), .timerCount(timerCount));

// ### tb_timer2_and_capture_compare_unit.sv
`timescale 1ns/10ps
module tb_timer2_and_capture_compare_unit;
  import tcc_pkg::*;
  typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} tcc_row_s;
  logic        clk = 1'h0, rst = 1'h1, regWr = 1'h0, regRd = 1'h0, t1Wr = 1'h0;
  logic        t1Run = 1'h0, pinIn = 1'h0, t1Ovf, pinOut, specialEvent, timerMatch;
  logic [7:0]  regAddr = 8'h00, regWdata = 8'h00, regRdata, timerCount, v;
  logic [15:0] t1Val = 16'h0000, t1Count;
  int          fail_count = 0, comparisons = 0, cycles = 0, n, ev;
  tcc_row_s rows[12] = '{'{1'h0, 8'h92, 8'h00, 8'hff}, '{1'h0, 8'h11, 8'h00, 8'h00},
    '{1'h0, 8'h12, 8'h00, 8'h00}, '{1'h0, 8'h0c, 8'h00, 8'h00}, '{1'h0, 8'h8c, 8'h00, 8'h00},
    '{1'h0, 8'h17, 8'h00, 8'h00}, '{1'h1, 8'h92, 8'h5a, 8'h5a}, '{1'h1, 8'h17, 8'hff, 8'h3f},
    '{1'h1, 8'h8c, 8'hff, 8'hf7}, '{1'h1, 8'h16, 8'hc3, 8'hc3}, '{1'h1, 8'h40, 8'hff, 8'h00},
    '{1'h1, 8'h0c, 8'h0b, 8'h03}};
  logic [7:0] cmpMode[5] = '{8'h08, 8'h0a, 8'h09, 8'h0a, 8'h08};
  logic [7:0] cmpPin[5] = '{8'h01, 8'h01, 8'h00, 8'h00, 8'h01};
  always #5 clk = ~clk;
  tcc_timer2_ccp dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .timerOneCount(t1Count),
    .timerOneWrite(t1Wr), .timerOneOvf(t1Ovf), .capcmpPinIn(pinIn), .capcmpPinOut(pinOut),
    .specialEvent(specialEvent), .timerMatch(timerMatch), .timerCount(timerCount));
  tcc_t1_model t1 (.clk(clk), .rst(rst), .run(t1Run), .wrEn(t1Wr), .wrVal(t1Val),
    .specialEvent(specialEvent), .count(t1Count), .ovf(t1Ovf));
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] s);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk8
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1'h1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    regRd <= 1'h1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'h0;
    #1 v = regRdata;
  endtask : rd
  task automatic t1Set(input logic [15:0] val);
    @(posedge clk);
    t1Wr <= 1'h1;
    t1Val <= val;
    @(posedge clk);
    t1Wr <= 1'h0;
  endtask : t1Set
  task automatic pulse();
    @(posedge clk);
    pinIn <= 1'h1;
    repeat (6) @(posedge clk);
    pinIn <= 1'h0;
    repeat (6) @(posedge clk);
  endtask : pulse
  task automatic waitMatch();
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (timerMatch !== 1'h1 && n < 600);
  endtask : waitMatch
  task automatic countEv(input int c);
    ev = 0;
    repeat (c) begin
      @(posedge clk);
      #1 ev += int'(specialEvent === 1'h1);
    end
  endtask : countEv
  task automatic end_sim();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      end_sim();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      chk8("register", rows[i].e, v);
    end
    wr(ADDR_CCCTRL, 8'h00);
    wr(ADDR_ENABLES, 8'h00);
    wr(ADDR_T2LIMIT, 8'h03);
    for (int p = 0; p < 4; p++) begin
      wr(ADDR_T2CTRL, 8'h04 | 8'(p));
      waitMatch();
      waitMatch();
      chk8("period", (p == 0) ? 8'h04 : (p == 1) ? 8'h10 : 8'h40, 8'(n));
    end
    wr(ADDR_T2CTRL, 8'h00);
    wr(ADDR_FLAGS, 8'h00);
    wr(ADDR_T2CTRL, 8'h0c);
    waitMatch();
    rd(ADDR_FLAGS);
    chk8("matchFlag", 8'h00, v & 8'h02);
    waitMatch();
    repeat (2) @(posedge clk);
    rd(ADDR_FLAGS);
    chk8("matchFlag", 8'h02, v & 8'h02);
    wr(ADDR_T2CTRL, 8'h00);
    wr(ADDR_T2COUNT, 8'h02);
    repeat (10) @(posedge clk);
    wr(ADDR_T2CTRL, 8'h78);
    rd(ADDR_T2COUNT);
    chk8("heldCount", 8'h02, v);
    chk8("mirror", 8'h02, timerCount);
    for (int m = 4; m < 8; m++) begin
      repeat (2) pulse();
      wr(ADDR_CCCTRL, 8'h00);
      wr(ADDR_CCCTRL, 8'(m));
      t1Set({8'ha5, 8'(m)});
      wr(ADDR_FLAGS, 8'h00);
      repeat ((m == 6) ? 3 : (m == 7) ? 15 : 0) pulse();
      rd(ADDR_FLAGS);
      chk8("earlyFlag", 8'h00, v & 8'h04);
      pulse();
      rd(ADDR_FLAGS);
      chk8("capFlag", 8'h04, v & 8'h04);
      rd(ADDR_CCVALLO);
      chk8("capLow", 8'(m), v);
      rd(ADDR_CCVALHI);
      chk8("capHigh", 8'ha5, v);
    end
    wr(ADDR_CCVALLO, 8'h40);
    wr(ADDR_CCVALHI, 8'h00);
    t1Run <= 1'h1;
    for (int k = 0; k < 5; k++) begin
      wr(ADDR_FLAGS, 8'h00);
      wr(ADDR_CCCTRL, cmpMode[k]);
      t1Set(16'h0030);
      repeat (40) @(posedge clk);
      #1 chk8("cmpPin", cmpPin[k], {7'h00, pinOut});
      rd(ADDR_FLAGS);
      chk8("cmpFlag", 8'h04, v & 8'h04);
    end
    wr(ADDR_CCCTRL, 8'h00);
    repeat (2) @(posedge clk);
    #1 chk8("offPin", 8'h00, {7'h00, pinOut});
    wr(ADDR_FLAGS, 8'h00);
    wr(ADDR_CCCTRL, 8'h0b);
    t1Set(16'h0030);
    countEv(40);
    chk8("events", 8'h01, 8'(ev));
    chk8("t1Cleared", 8'h01, {7'h00, t1Count < 16'h0030});
    rd(ADDR_FLAGS);
    chk8("trigFlags", 8'h04, v & 8'h05);
    @(posedge clk);
    t1Wr <= 1'h1;
    t1Val <= 16'h0040;
    countEv(20);
    t1Wr <= 1'h0;
    chk8("heldEvents", 8'h00, 8'(ev));
    @(posedge clk);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    rd(ADDR_T2LIMIT);
    chk8("rstLimit", 8'hff, v);
    rd(ADDR_T2COUNT);
    chk8("rstCount", 8'h00, v);
    chk8("rstMirror", 8'h00, timerCount);
    chk8("rstPin", 8'h00, {7'h00, pinOut});
    end_sim();
  end
endmodule : tb_timer2_and_capture_compare_unit
